// ---- urxaf_top.sv ----
// UART receiver for 10/11-bit frames with address filter and APB registers
//
// Function
// - Oversample the line at sixteen times baud; start on a falling edge.
// - On that edge reset the sixteen-state bit counter at once.
// - Sample at counter states seven, eight, nine; take two-of-three majority.
// - A first bit not zero abandons the frame and waits for a new edge.
// - 10-bit frame loads only if flag clear and (no multiproc or stop one).
// - Accepted 10-bit frame puts stop bit in ninth bit, data in buffer.
// - 11-bit frames use the same start detection and majority sampling.
// - 11-bit frame loads only if flag clear and (no multiproc or ninth one with address match).
// - Accepted 11-bit frame stores ninth bit and data; rejected frame is lost.
// - Multiproc enable has no effect in shift-register mode.
// - With multiproc in 11-bit modes, flag needs ninth one and address match.
// - Given address compares only bits whose mask bit is one.
// - Broadcast is address OR mask; its zero bits are don't-cares.
// - Reset clears address and mask so every byte matches.
// - 11-bit frame is start zero, eight bits LSB first, ninth, stop one.
// - Receive flag rises near the middle of the stop bit.
// - Framing error flag sets on a bad stop bit; only software clears it.
`timescale 1ns/1ps
`default_nettype none

module urxaf_top
  import urxaf_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        baud_tick16,
  input  wire logic        rxd,
  output logic             irq
);

  // ****************************************
  // Declarations
  // ****************************************
  logic             rxd_meta_ff;
  logic             rxd_sync_ff;
  logic             rxd_prev_ff;
  urxaf_ctrl_s      ctrl_ff;
  logic [7:0]       slave_addr_reg_ff;
  logic [7:0]       smask_ff;
  logic [7:0]       rxbuf_ff;
  logic             rb8_ff;
  urxaf_evt_s       evt_ff;
  urxaf_evt_s       imask_ff;
  urxaf_state_e     state_ff;
  logic [CNT_W-1:0] cnt_ff;
  logic [3:0]       bit_idx_ff;
  logic [8:0]       shift_ff;
  logic [31:0]      prdata_ff;
  logic [31:0]      nxt_prdata;
  logic             addr_ok;
  logic             setup_ph;
  logic             access_ph;
  logic             wr_en;
  logic             bit_done;
  logic             bit_val;
  logic             addr_hit;
  logic             rx_active;
  logic             fall_seen;
  logic             mode_eleven;
  logic             frame_end;
  logic             accept;
  logic             load_ok;
  logic             fe_set;
  logic [7:0]       rx_byte;
  logic [3:0]       last_idx;
  urxaf_evt_s       evt_clr;

  // ****************************************
  // APB slave
  // ****************************************

  // Zero-wait slave: read data captured in setup
  assign setup_ph  = psel & ~penable;
  assign access_ph = psel & penable;
  assign wr_en     = access_ph & pwrite & pstrb[0] & addr_ok;
  assign pready    = 1'b1;
  assign pslverr   = access_ph & ~addr_ok;
  assign prdata    = prdata_ff;

  // Address decode and read mux
  always_comb
  begin
    addr_ok    = 1'b1;
    nxt_prdata = 32'h0000_0000;
    if (paddr[31:ADDR_LOW] != '0)
      addr_ok = 1'b0;
    else if (paddr[4:0] == OFF_CTRL)
      nxt_prdata[4:0] = ctrl_ff;
    else if (paddr[4:0] == OFF_STAT)
      nxt_prdata[2:0] = {rb8_ff, evt_ff};
    else if (paddr[4:0] == OFF_RXBUF)
      nxt_prdata[7:0] = rxbuf_ff;
    else if (paddr[4:0] == OFF_SLAVE_ADDR_REG)
      nxt_prdata[7:0] = slave_addr_reg_ff;
    else if (paddr[4:0] == OFF_SMASK)
      nxt_prdata[7:0] = smask_ff;
    else if (paddr[4:0] == OFF_IMASK)
      nxt_prdata[1:0] = imask_ff;
    else
      addr_ok = 1'b0;
  end

  // Read data register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata_ff <= 32'h0000_0000;
    else if (setup_ph)
      prdata_ff <= nxt_prdata;
  end

  // Software-written configuration
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_ff  <= CTRL_RST;
      slave_addr_reg_ff <= SLAVE_ADDR_REG_RST;
      smask_ff <= SMASK_RST;
      imask_ff <= IMASK_RST;
    end
    else if (wr_en)
    begin
      if (paddr[4:0] == OFF_CTRL)
        ctrl_ff <= pwdata[4:0];
      else if (paddr[4:0] == OFF_SLAVE_ADDR_REG)
        slave_addr_reg_ff <= pwdata[7:0];
      else if (paddr[4:0] == OFF_SMASK)
        smask_ff <= pwdata[7:0];
      else if (paddr[4:0] == OFF_IMASK)
        imask_ff <= pwdata[1:0];
    end
  end

  // Write-one-to-clear request on status
  assign evt_clr = (wr_en && paddr[4:0] == OFF_STAT) ? pwdata[1:0] : 2'h0;

  // ****************************************
  // Line synchroniser and start detection
  // ****************************************

  // Two flops before any logic reads the line
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rxd_meta_ff <= 1'b1;
      rxd_sync_ff <= 1'b1;
    end
    else
    begin
      rxd_meta_ff <= rxd;
      rxd_sync_ff <= rxd_meta_ff;
    end
  end

  // Line level at the previous oversample tick
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rxd_prev_ff <= 1'b1;
    else if (baud_tick16)
      rxd_prev_ff <= rxd_sync_ff;
  end

  // Shift-register mode leaves the receiver idle
  assign rx_active = ctrl_ff.rx_enable && (ctrl_ff.mode != MODE_SHIFT);
  assign fall_seen = rx_active && (state_ff == ST_IDLE) && baud_tick16
                     && rxd_prev_ff && !rxd_sync_ff;

  // Sixteen-state bit counter, cleared by the start edge
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cnt_ff <= '0;
    else if (fall_seen)
      cnt_ff <= '0;
    else if (state_ff != ST_IDLE && baud_tick16)
      cnt_ff <= cnt_ff + 4'h1;
  end

  // Majority sampling shared by all frame modes
  urxaf_bit_sampler u_sampler (
    .pclk     (pclk),
    .presetn  (presetn),
    .tick     (baud_tick16 && state_ff != ST_IDLE),
    .cnt      (cnt_ff),
    .rxd_s    (rxd_sync_ff),
    .bit_done (bit_done),
    .bit_val  (bit_val)
  );

  // ****************************************
  // Frame sequencing
  // ****************************************
  assign mode_eleven = ctrl_ff.mode[1];
  assign last_idx    = mode_eleven ? LAST_ELEV : LAST_TEN;

  // State, bit index and input shift register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_ff   <= ST_IDLE;
      bit_idx_ff <= 4'h0;
      shift_ff   <= 9'h000;
    end
    else if (!rx_active)
      state_ff <= ST_IDLE;
    else
    begin
      case (state_ff)
        ST_IDLE:
          if (fall_seen)
            state_ff <= ST_START;
        ST_START:
          if (bit_done)
          begin
            bit_idx_ff <= 4'h0;
            state_ff   <= bit_val ? ST_IDLE : ST_DATA;
          end
        ST_DATA:
          if (bit_done)
          begin
            shift_ff   <= {bit_val, shift_ff[8:1]};
            bit_idx_ff <= bit_idx_ff + 4'h1;
            if (bit_idx_ff == last_idx)
              state_ff <= ST_STOP;
          end
        ST_STOP:
          if (bit_done)
            state_ff <= ST_IDLE;
        default:
          state_ff <= ST_IDLE;
      endcase
    end
  end

  // Data byte sits high after eight shifts, low after nine
  assign rx_byte = mode_eleven ? shift_ff[7:0] : shift_ff[8:1];

  // Address check on the first eight bits
  urxaf_addr_match u_match (
    .rx_byte    (shift_ff[7:0]),
    .slave_addr (slave_addr_reg_ff),
    .slave_mask (smask_ff),
    .hit        (addr_hit)
  );

  // ****************************************
  // Load decision at the stop bit
  // ****************************************

  // Final shift pulse falls mid stop bit
  assign frame_end = (state_ff == ST_STOP) && bit_done;

  // Acceptance per frame mode
  always_comb
  begin
    if (!mode_eleven)
      accept = !evt_ff.receive_flag
               && (!ctrl_ff.multiproc_enable || bit_val);
    else
      accept = !evt_ff.receive_flag
               && (!ctrl_ff.multiproc_enable
                   || (shift_ff[8] && addr_hit));
  end

  assign load_ok = frame_end && accept;
  assign fe_set  = frame_end && ctrl_ff.frame_err_select && !bit_val;

  // Receive buffer and ninth bit load
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rxbuf_ff <= 8'h00;
      rb8_ff   <= 1'b0;
    end
    else if (load_ok)
    begin
      rxbuf_ff <= rx_byte;
      rb8_ff   <= mode_eleven ? shift_ff[8] : bit_val;
    end
  end

  // Sticky events; a set beats a same-cycle clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      evt_ff <= 2'h0;
    else
    begin
      evt_ff.receive_flag <= (evt_ff.receive_flag & ~evt_clr.receive_flag)
                             | load_ok;
      evt_ff.framing_error_flag <= (evt_ff.framing_error_flag
                                   & ~evt_clr.framing_error_flag)
                                   | fe_set;
    end
  end

  // Level interrupt from unmasked events
  assign irq = |(evt_ff & imask_ff);

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_start_clears_cnt:
  assert property (fall_seen |=> (cnt_ff == 4'h0) && (state_ff == ST_START))
  else $error("start edge did not clear counter");

  a_false_start_drop:
  assert property (state_ff == ST_START && bit_done && bit_val && rx_active
                   |=> state_ff == ST_IDLE)
  else $error("false start not rejected");

  a_flag_needs_clear:
  assert property ($rose(evt_ff.receive_flag)
                   |-> $past(frame_end) && !$past(evt_ff.receive_flag))
  else $error("receive flag set outside clear frame end");

  a_ten_stop_store:
  assert property ($rose(evt_ff.receive_flag) && !$past(mode_eleven)
                   |-> rb8_ff == $past(bit_val) && rxbuf_ff == $past(shift_ff[8:1]))
  else $error("10-bit frame stored wrongly");

  a_ninth_gate:
  assert property ($rose(evt_ff.receive_flag)
                   && $past(mode_eleven && ctrl_ff.multiproc_enable) |-> rb8_ff)
  else $error("data frame passed multiproc gate");

  a_eleven_store:
  assert property ($rose(evt_ff.receive_flag) && $past(mode_eleven)
                   |-> rxbuf_ff == $past(shift_ff[7:0]) && rb8_ff == $past(shift_ff[8]))
  else $error("11-bit frame stored wrongly");

  a_addr_filter:
  assert property ($rose(evt_ff.receive_flag)
                   && $past(mode_eleven && ctrl_ff.multiproc_enable) |-> $past(addr_hit))
  else $error("unmatched address raised flag");

  a_lost_frame:
  assert property (frame_end && evt_ff.receive_flag
                   |=> rxbuf_ff == $past(rxbuf_ff))
  else $error("buffer overwritten while flag set");

  a_reset_match_all:
  assert property (slave_addr_reg_ff == 8'h00 && smask_ff == 8'h00 |-> addr_hit)
  else $error("cleared filter rejected a byte");

  a_fe_sticky:
  assert property (evt_ff.framing_error_flag && !evt_clr.framing_error_flag
                   |=> evt_ff.framing_error_flag)
  else $error("framing error cleared by hardware");

  a_shift_mode_idle:
  assert property (ctrl_ff.mode == MODE_SHIFT |=> state_ff == ST_IDLE)
  else $error("receiver active in shift mode");

endmodule : urxaf_top

`default_nettype wire

// ---- urxaf_pkg.sv ----
// Shared constants and types of the UART receiver with address filter
package urxaf_pkg;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [4:0] OFF_CTRL  = 5'h00;
  localparam logic [4:0] OFF_STAT  = 5'h04;
  localparam logic [4:0] OFF_RXBUF = 5'h08;
  localparam logic [4:0] OFF_SLAVE_ADDR_REG = 5'h0c;
  localparam logic [4:0] OFF_SMASK = 5'h10;
  localparam logic [4:0] OFF_IMASK = 5'h14;
  localparam int unsigned ADDR_LOW = 5;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int unsigned STB_RI  = 0;
  localparam int unsigned STB_FE  = 1;
  localparam int unsigned STB_RB8 = 2;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [4:0] CTRL_RST  = 5'h00;
  localparam logic [7:0] SLAVE_ADDR_REG_RST = 8'h00;
  localparam logic [7:0] SMASK_RST = 8'h00;
  localparam logic [1:0] IMASK_RST = 2'h0;

  // ****************************************
  // Modes and oversampling counts
  // ****************************************
  localparam logic [1:0] MODE_SHIFT = 2'h0;
  localparam logic [1:0] MODE_TEN   = 2'h1;
  localparam int unsigned CNT_W     = 4;
  localparam logic [3:0] CNT_S1     = 4'h7;
  localparam logic [3:0] CNT_S2     = 4'h8;
  localparam logic [3:0] CNT_S3     = 4'h9;
  localparam logic [3:0] LAST_TEN   = 4'h7;
  localparam logic [3:0] LAST_ELEV  = 4'h8;

  // Control register layout, mode in the low bits
  typedef struct packed {
    logic       frame_err_select;
    logic       multiproc_enable;
    logic       rx_enable;
    logic [1:0] mode;
  } urxaf_ctrl_s;

  // Sticky event bits, same layout as the mask
  typedef struct packed {
    logic framing_error_flag;
    logic receive_flag;
  } urxaf_evt_s;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_START,
    ST_DATA,
    ST_STOP
  } urxaf_state_e;

endpackage : urxaf_pkg

// ---- urxaf_bit_sampler.sv ----
// Two-of-three majority sampler for one oversampled bit time
`timescale 1ns/1ps
`default_nettype none

module urxaf_bit_sampler
  import urxaf_pkg::*;
(
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             tick,
  input  wire logic [CNT_W-1:0] cnt,
  input  wire logic             rxd_s,
  output logic                  bit_done,
  output logic                  bit_val
);

  logic s1_ff;
  logic s2_ff;
  logic done_ff;
  logic val_ff;
  logic at_s3;

  assign at_s3 = tick && (cnt == CNT_S3);

  // First two samples of the bit time
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s1_ff <= 1'b1;
      s2_ff <= 1'b1;
    end
    else
    begin
      if (tick && cnt == CNT_S1)
        s1_ff <= rxd_s;
      if (tick && cnt == CNT_S2)
        s2_ff <= rxd_s;
    end
  end

  // Third sample decides by majority
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      done_ff <= 1'b0;
      val_ff  <= 1'b1;
    end
    else
    begin
      done_ff <= at_s3;
      if (at_s3)
        val_ff <= (s1_ff & s2_ff) | (s1_ff & rxd_s) | (s2_ff & rxd_s);
    end
  end

  assign bit_done = done_ff;
  assign bit_val  = val_ff;

  a_two_of_three:
  assert property (@(posedge pclk) disable iff (!presetn)
    at_s3 |=> bit_done && (bit_val == (($past(s1_ff) + $past(s2_ff) + $past(rxd_s)) >= 2'd2)))
  else $error("majority bit value wrong");

endmodule : urxaf_bit_sampler

`default_nettype wire

// ---- urxaf_addr_match.sv ----
// Given and broadcast address comparison for address frames
`timescale 1ns/1ps
`default_nettype none

module urxaf_addr_match
  import urxaf_pkg::*;
(
  input  wire logic [7:0] rx_byte,
  input  wire logic [7:0] slave_addr,
  input  wire logic [7:0] slave_mask,
  output logic            hit
);

  logic [7:0] bcast;
  logic       given_hit;
  logic       bcast_hit;

  // Masked compare; zero mask bits are ignored
  assign given_hit = ((rx_byte ^ slave_addr) & slave_mask) == 8'h00;
  // Broadcast is the OR; its zeros are don't-cares
  assign bcast     = slave_addr | slave_mask;
  assign bcast_hit = ((rx_byte ^ bcast) & bcast) == 8'h00;
  assign hit       = given_hit | bcast_hit;

endmodule : urxaf_addr_match

`default_nettype wire

// ---- urxaf_tx_model.sv ----
// Behavioural serial transmitter standing for the remote processor
`timescale 1ns/1ps
`default_nettype none

module urxaf_tx_model
(
  input  wire logic pclk,
  input  wire logic tick,
  output logic      rxd
);
  // ****************************************
  // Line driver
  // ****************************************
  // Line idles high between frames
  initial rxd = 1'b1;

  // Wait for the next oversampling tick
  task automatic wait_tick();
    do @(posedge pclk); while (tick !== 1'b1);
  endtask : wait_tick

  // Send n bits LSB first, 16 ticks each; tick 8 of bit g is inverted as noise
  task automatic send(input logic [10:0] bits, input int n, input int g);
    for (int i = 0; i < n; i++)
    begin
      for (int k = 0; k < 16; k++)
      begin
        wait_tick();
        rxd <= (i == g && k == 8) ? ~bits[i] : bits[i];
      end
    end
    // One idle bit time so the next start edge is clean
    for (int k = 0; k < 16; k++)
    begin
      wait_tick();
      rxd <= 1'b1;
    end
  endtask : send
endmodule : urxaf_tx_model
`default_nettype wire

// ---- tb_urxaf_top.sv ----
// Self-checking bench of the receiver with address filter
`timescale 1ns/1ps
`default_nettype none

module tb_urxaf_top
  import urxaf_pkg::*;
;
  // ****************************************
  // Signals and expectation state
  // ****************************************
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [31:0] paddr, pwdata, prdata, rd;
  logic [3:0]  pstrb;
  logic        baud_tick16, rxd, irq, er;
  logic [1:0]  tcnt;
  logic [7:0]  slave_addr_reg, smask, ebuf;
  logic        eflag, efe, erb8;
  logic [1:0]  eimask;
  int          n_errors, n_compared, seed;

  urxaf_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .baud_tick16(baud_tick16), .rxd(rxd), .irq(irq));
  urxaf_tx_model u_tx (.pclk(pclk), .tick(baud_tick16), .rxd(rxd));

  // Clock and a 16x tick every fourth cycle
  always #2.5 pclk = ~pclk;
  always @(posedge pclk)
  begin
    tcnt        <= tcnt + 2'h1;
    baud_tick16 <= (tcnt == 2'h3);
  end

  // ****************************************
  // Tasks
  // ****************************************
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : end_sim

  // One APB transfer; waits for pready with no bound of its own
  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // Access phase held until ready is seen; only the watchdog ends a hang
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb

  task automatic set_addr(input logic [7:0] a, input logic [7:0] m);
    apb(1'b1, 32'h0c, {24'h0, a});
    apb(1'b1, 32'h10, {24'h0, m});
    slave_addr_reg = a;
    smask = m;
  endtask : set_addr

  // One frame sent and judged; expectation follows the load conditions
  task automatic frame(input logic [1:0] md, input logic mpe, input logic fes, input logic [7:0] b,
                       input logic nb, input int g, input logic clr);
    logic hit, acc;
    hit = (((b ^ slave_addr_reg) & smask) == 8'h00) || ((b & (slave_addr_reg | smask)) == (slave_addr_reg | smask));
    acc = (md != MODE_SHIFT) && !eflag && (!mpe || (nb && (md == MODE_TEN || hit)));
    apb(1'b1, 32'h00, {27'h0, fes, mpe, 1'b1, md});
    u_tx.send({1'b1, nb, b, 1'b0}, (md == MODE_TEN) ? 10 : 11, g);
    if (acc)
    begin
      ebuf  = b;
      erb8  = nb;
      eflag = 1'b1;
    end
    if (md == MODE_TEN && fes && !nb) efe = 1'b1;
    apb(1'b0, 32'h04, 32'h0);
    chk("status", rd, {29'h0, erb8, efe, eflag});
    apb(1'b0, 32'h08, 32'h0);
    chk("rx_buffer", rd, {24'h0, ebuf});
    chk("irq", {31'h0, irq}, {31'h0, |(eimask & {efe, eflag})});
    if (clr)
    begin
      apb(1'b1, 32'h04, 32'h3);
      eflag = 1'b0;
      efe   = 1'b0;
      // The clear lands at the access edge; look once it has settled
      @(posedge pclk);
      chk("irq clear", {31'h0, irq}, 32'h0);
    end
  endtask : frame

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
    pstrb = 4'hf; tcnt = 0; baud_tick16 = 0; seed = 32'hf163;
    n_errors = 0; n_compared = 0; slave_addr_reg = 0; smask = 0; ebuf = 0;
    eflag = 0; efe = 0; erb8 = 0; eimask = 0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    // Every register reads zero after reset
    for (int a = 0; a < 6; a++)
    begin
      apb(1'b0, 32'(a * 4), 32'h0);
      chk("reset value", rd, 32'h0);
    end
    apb(1'b0, 32'h18, 32'h0);
    chk("unmapped error", {31'h0, er}, 32'h1);
    chk("pready", {31'h0, pready}, 32'h1);
    pstrb <= 4'h0;
    apb(1'b1, 32'h0c, 32'h55);
    pstrb <= 4'hf;
    apb(1'b0, 32'h0c, 32'h0);
    chk("strobe off write", rd, 32'h0);
    apb(1'b1, 32'h14, 32'h3);
    eimask = 2'h3;
    // Corner cases: flag held, bad stop, noise, false start, idle mode
    frame(MODE_TEN, 1'b0, 1'b0, 8'ha5, 1'b1, 99, 1'b0);
    frame(MODE_TEN, 1'b0, 1'b0, 8'h3c, 1'b1, 99, 1'b1);
    frame(MODE_TEN, 1'b1, 1'b1, 8'h11, 1'b0, 99, 1'b0);
    frame(MODE_TEN, 1'b0, 1'b1, 8'h22, 1'b1, 99, 1'b1);
    u_tx.send(11'h7ff, 1, 0);
    frame(MODE_TEN, 1'b0, 1'b0, 8'h5a, 1'b1, 3, 1'b1);
    frame(MODE_SHIFT, 1'b1, 1'b0, 8'h77, 1'b1, 99, 1'b1);
    // Receiver disabled in a frame mode: a valid frame must leave status alone
    apb(1'b1, 32'h00, 32'h1);
    u_tx.send(11'h6ee, 10, 99);
    apb(1'b0, 32'h04, 32'h0);
    chk("rx disabled", rd, {29'h0, erb8, efe, eflag});
    frame(2'h2, 1'b1, 1'b0, 8'hc3, 1'b1, 99, 1'b1);
    frame(2'h3, 1'b1, 1'b0, 8'hc3, 1'b0, 99, 1'b1);
    // Random frames over modes, filter settings and noise
    for (int i = 0; i < 24; i++)
    begin
      logic [7:0] r;
      r = 8'($random(seed));
      set_addr(8'($random(seed)), 8'($random(seed)));
      case (r[1:0])
        2'h0: r = slave_addr_reg | (8'($random(seed)) & ~smask);
        2'h1: r = slave_addr_reg | smask | 8'($random(seed));
        default: r = 8'($random(seed));
      endcase
      frame(2'(32'($unsigned($random(seed))) % 3 + 1), 1'($random(seed)), 1'($random(seed)), r,
            1'($random(seed)), 32'($unsigned($random(seed))) % 12, 1'($random(seed)) | r[7]);
    end
    end_sim();
  end

  // Watchdog against a hung handshake or receiver
  initial
  begin
    #300000;
    n_errors++;
    end_sim();
  end
endmodule : tb_urxaf_top
`default_nettype wire
